/* verilog/gpx_pkg.sv */
// Package for the general-purpose pin port: register map, bank layout and helpers
// Functional notes
// - Port offers 67 main-domain pins and 20 always-on pins, each pin independent.
// - Main pins split into banks: 0-21, 22-48, 49-66; always-on pins form fourth bank.
// - Each pin output value bit drives that pad's output buffer.
// - Direction register bit chooses per pad between driven output and input.
// - Read-only pad input register returns each pad level, whatever the direction.
// - Each pin can interrupt on high level, low level, rising or falling edge.
// - Per-pin mask gates interrupts; raw and masked status are both readable.
// - All pin interrupts OR into one output; it has no mask of its own.
// - New interrupts latch only on input pins; pending ones survive a switch to output.
// - Writing one to edge-clear clears that pin's edge interrupt, raw and masked.
// - Edge-clear writes do nothing to pins in level-sensitive mode.
// - Level interrupt stays while its source holds; removed by source clearing or mask.
// - One edge-clear write may clear many pins at once.
// - Edge detection always works on samples synchronised to the bus clock.
// - Level interrupts use synchronised or direct pad level, chosen by software.
`default_nettype none
package gpx_pkg;
    // Pin counts and bank layout
    localparam int GPX_MAIN_PINS = 67;
    localparam int GPX_AON_PINS  = 20;
    localparam int GPX_NUM_BANKS = 4;
    localparam int GPX_MAIN_BANKS = 3;
    localparam int GPX_BANK_W   [GPX_NUM_BANKS] = '{22, 27, 18, 20};
    localparam int GPX_BANK_LSB [GPX_NUM_BANKS] = '{0, 22, 49, 0};
    localparam int GPX_WORD_W = 32;

    // Address layout: bank index above, register offset below
    localparam int GPX_ADDR_W   = 8;
    localparam int GPX_BANK_MSB = 7;
    localparam int GPX_BANK_LSB_A = 6;
    localparam int GPX_REG_MSB  = 5;
    localparam logic [5:0] GPX_REG_OUT   = 6'h00;
    localparam logic [5:0] GPX_REG_DIR   = 6'h04;
    localparam logic [5:0] GPX_REG_INTEN = 6'h08;
    localparam logic [5:0] GPX_REG_MASK  = 6'h0C;
    localparam logic [5:0] GPX_REG_TRIG  = 6'h10;
    localparam logic [5:0] GPX_REG_POL   = 6'h14;
    localparam logic [5:0] GPX_REG_LSYNC = 6'h18;
    localparam logic [5:0] GPX_REG_RAW   = 6'h1C;
    localparam logic [5:0] GPX_REG_STAT  = 6'h20;
    localparam logic [5:0] GPX_REG_EOI   = 6'h24;
    localparam logic [5:0] GPX_REG_PADIN = 6'h28;

    // Every control register resets to this
    localparam logic [31:0] GPX_RST_VALUE = 32'h0000_0000;

    // Valid bits of a bank word; bits above the bank width read zero
    function automatic logic [31:0] gpxBankMask(input int b);
        logic [63:0] m;
        m = (64'h1 << GPX_BANK_W[b]) - 64'h1;
        return m[31:0];
    endfunction
endpackage
`default_nettype wire

/* verilog/gpx_pin_detect.sv */
// Pad synchroniser and edge finder for one bank of pins
`timescale 1ns/1ps
`default_nettype none
module gpx_pin_detect #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] padIn,
    output logic      [WIDTH-1:0] syncLvl,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } gpx_det_state_t;

    gpx_det_state_t s_r;
    gpx_det_state_t s_nxt;

    // Two-flop chain, then one more sample to compare against
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = padIn;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Only the second flop and the previous sample feed the comparators
    assign syncLvl = s_r.sync;
    assign rise    = s_r.sync & ~s_r.prev;
    assign fall    = ~s_r.sync & s_r.prev;
endmodule // gpx_pin_detect
`default_nettype wire

/* verilog/gpx_port.sv */
// General-purpose pin port with per-pin interrupts and register port
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gpx_port
    import gpx_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [GPX_ADDR_W-1:0]    addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [31:0]              rdata,
    input  wire logic [GPX_MAIN_PINS-1:0] mainPadIn,
    output logic      [GPX_MAIN_PINS-1:0] mainPadOut,
    output logic      [GPX_MAIN_PINS-1:0] mainPadOe,
    input  wire logic [GPX_AON_PINS-1:0]  aonPadIn,
    output logic      [GPX_AON_PINS-1:0]  aonPadOut,
    output logic      [GPX_AON_PINS-1:0]  aonPadOe,
    output logic                          irq
);
    localparam int NB = GPX_NUM_BANKS;

    // Later checks share the bus clock and sleep through reset
    default clocking cbDefault @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    typedef logic [NB-1:0][31:0] gpx_bank_words_t;

    // Whole register state of the port
    typedef struct packed {
        gpx_bank_words_t outVal;
        gpx_bank_words_t dir;       // 1 = output
        gpx_bank_words_t intEn;
        gpx_bank_words_t intMask;   // 1 = masked
        gpx_bank_words_t trigEdge;  // 1 = edge, 0 = level
        gpx_bank_words_t polHigh;   // 1 = high level or rising edge
        gpx_bank_words_t lvlSync;   // 1 = level path uses synchronised pad
        gpx_bank_words_t edgeRaw;
        logic [31:0]     rdata;
    } gpx_port_state_t;

    gpx_port_state_t s_r;
    gpx_port_state_t s_nxt;

    gpx_bank_words_t padInBank;
    gpx_bank_words_t syncBank;
    gpx_bank_words_t riseBank;
    gpx_bank_words_t fallBank;
    gpx_bank_words_t rawStat;
    gpx_bank_words_t maskStat;
    gpx_bank_words_t edgeSet;

    logic [1:0] bankSel;
    logic [5:0] regSel;

    assign bankSel = addr[GPX_BANK_MSB:GPX_BANK_LSB_A];
    assign regSel  = addr[GPX_REG_MSB:0];

    // Gather pads into bank words and drive pad outputs from the registers
    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_bank
            localparam int W   = GPX_BANK_W[b];
            localparam int LSB = GPX_BANK_LSB[b];
            if (b < GPX_MAIN_BANKS) begin : g_main
                assign padInBank[b] = 32'(mainPadIn[LSB +: W]);
                assign mainPadOut[LSB +: W] = s_r.outVal[b][W-1:0];
                assign mainPadOe[LSB +: W]  = s_r.dir[b][W-1:0];
            end else begin : g_aon
                assign padInBank[b] = 32'(aonPadIn[LSB +: W]);
                assign aonPadOut = s_r.outVal[b][W-1:0];
                assign aonPadOe  = s_r.dir[b][W-1:0];
            end
            // Unused upper bits of each word are tied low and get pruned
            gpx_pin_detect #(
                .WIDTH (GPX_WORD_W)
            ) u_det (
                .clk     (clk),
                .rst_n   (rst_n),
                .padIn   (padInBank[b]),
                .syncLvl (syncBank[b]),
                .rise    (riseBank[b]),
                .fall    (fallBank[b])
            );
        end
    endgenerate

    // Interrupt status per bank, from edge latches and live level conditions
    always_comb begin
        logic [31:0] armed;
        logic [31:0] lvlSrc;
        logic [31:0] lvlHit;
        armed  = '0;
        lvlSrc = '0;
        lvlHit = '0;
        for (int i = 0; i < NB; i++) begin
            // Only enabled input pins may raise anything new
            armed = s_r.intEn[i] & ~s_r.dir[i] & gpxBankMask(i);
            // Software picks synchronised or direct pad for level triggers
            lvlSrc = (s_r.lvlSync[i] & syncBank[i])
                   | (~s_r.lvlSync[i] & padInBank[i]);
            lvlHit = ~(lvlSrc ^ s_r.polHigh[i]);
            edgeSet[i] = ((riseBank[i] & s_r.polHigh[i])
                        | (fallBank[i] & ~s_r.polHigh[i]))
                       & s_r.trigEdge[i] & armed;
            // Level status follows the source with no latch
            rawStat[i] = s_r.edgeRaw[i] | (lvlHit & ~s_r.trigEdge[i] & armed);
            maskStat[i] = rawStat[i] & ~s_r.intMask[i];
        end
    end

    // Combined request: plain OR of masked status, with no mask of its own
    assign irq = |maskStat;

    // Register writes, edge latching and read data
    always_comb begin
        logic [31:0] eoiClr;
        logic [31:0] wmask;
        s_nxt  = s_r;
        eoiClr = '0;
        wmask  = '0;
        for (int i = 0; i < NB; i++) begin
            wmask  = gpxBankMask(i);
            eoiClr = '0;
            if (wr && (bankSel == 2'(i))) begin
                unique case (regSel)
                    GPX_REG_OUT:   s_nxt.outVal[i]   = wdata & wmask;
                    GPX_REG_DIR:   s_nxt.dir[i]      = wdata & wmask;
                    GPX_REG_INTEN: s_nxt.intEn[i]    = wdata & wmask;
                    GPX_REG_MASK:  s_nxt.intMask[i]  = wdata & wmask;
                    GPX_REG_TRIG:  s_nxt.trigEdge[i] = wdata & wmask;
                    GPX_REG_POL:   s_nxt.polHigh[i]  = wdata & wmask;
                    GPX_REG_LSYNC: s_nxt.lvlSync[i]  = wdata & wmask;
                    // Level pins ignore the clear; many bits clear at once
                    GPX_REG_EOI:   eoiClr = wdata & s_r.trigEdge[i];
                    default:       eoiClr = '0;
                endcase
            end
            // A new edge in the clearing cycle wins over the clear
            s_nxt.edgeRaw[i] = (s_r.edgeRaw[i] & ~eoiClr) | edgeSet[i];
        end
        // Read data valid only in the cycle after the strobe
        s_nxt.rdata = GPX_RST_VALUE;
        if (rd) begin
            unique case (regSel)
                GPX_REG_OUT:   s_nxt.rdata = s_r.outVal[bankSel];
                GPX_REG_DIR:   s_nxt.rdata = s_r.dir[bankSel];
                GPX_REG_INTEN: s_nxt.rdata = s_r.intEn[bankSel];
                GPX_REG_MASK:  s_nxt.rdata = s_r.intMask[bankSel];
                GPX_REG_TRIG:  s_nxt.rdata = s_r.trigEdge[bankSel];
                GPX_REG_POL:   s_nxt.rdata = s_r.polHigh[bankSel];
                GPX_REG_LSYNC: s_nxt.rdata = s_r.lvlSync[bankSel];
                GPX_REG_RAW:   s_nxt.rdata = rawStat[bankSel];
                GPX_REG_STAT:  s_nxt.rdata = maskStat[bankSel];
                GPX_REG_PADIN: s_nxt.rdata = padInBank[bankSel];
                default:       s_nxt.rdata = GPX_RST_VALUE;
            endcase
        end
    end

    // Synchronous reset: all controls zero, so every pad starts as input
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;

    // Checks on banks 0, 1 and 3 and on pins 0 and 2 of bank 0 stand for all pins
    AST_OUT_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && bankSel == 2'h0 && regSel == GPX_REG_OUT)
        |=> mainPadOut[21:0] == $past(wdata[21:0]))
        else $error("pad output does not follow written value");

    AST_DIR_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && bankSel == 2'h3 && regSel == GPX_REG_DIR)
        |=> aonPadOe == $past(wdata[19:0]))
        else $error("pad enable does not follow direction write");

    AST_PADIN_READ: assert property (@(posedge clk) disable iff (!rst_n)
        (rd && bankSel == 2'h1 && regSel == GPX_REG_PADIN)
        |=> rdata == {5'h00, $past(mainPadIn[48:22])})
        else $error("pad input read returns wrong level");

    AST_MASKED_READ: assert property (@(posedge clk) disable iff (!rst_n)
        (rd && bankSel == 2'h0 && regSel == GPX_REG_STAT)
        |=> rdata == ($past(rawStat[0]) & ~$past(s_r.intMask[0])))
        else $error("masked status read wrong");

    AST_IRQ_OR: assert property (@(posedge clk) disable iff (!rst_n)
        irq == ((|(rawStat[0] & ~s_r.intMask[0])) || (|(rawStat[1] & ~s_r.intMask[1]))
             || (|(rawStat[2] & ~s_r.intMask[2])) || (|(rawStat[3] & ~s_r.intMask[3]))))
        else $error("combined request disagrees with pin status");

    AST_NO_OUT_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.dir[0][0] |-> !edgeSet[0][0])
        else $error("edge latched on an output pin");

    AST_EOI_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && bankSel == 2'h0 && regSel == GPX_REG_EOI && wdata[0]
         && s_r.trigEdge[0][0] && !edgeSet[0][0])
        |=> !s_r.edgeRaw[0][0])
        else $error("edge clear did not clear status");

    AST_EOI_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && bankSel == 2'h0 && regSel == GPX_REG_EOI)
        |=> ((s_r.edgeRaw[0] ^ $past(s_r.edgeRaw[0])) & ~$past(s_r.trigEdge[0])) == 32'h0)
        else $error("edge clear touched a level pin");

    AST_SYNC_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
        riseBank[0][0] |-> ($past(mainPadIn[0], 2) && !$past(mainPadIn[0], 3)))
        else $error("rising edge not seen through synchroniser");

    AST_LEVEL_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (!s_r.trigEdge[0][2] && !s_r.lvlSync[0][2] && (mainPadIn[2] == s_r.polHigh[0][2])
         && s_r.intEn[0][2] && !s_r.dir[0][2] && !s_r.intMask[0][2])
        |-> irq && rawStat[0][2])
        else $error("level request missing while source holds");

    // Pad outputs and enables of the other banks follow their writes
    AST_OUT_B1: assert property (
        (wr && bankSel == 2'h1 && regSel == GPX_REG_OUT)
        |=> mainPadOut[48:22] == $past(wdata[26:0]))
        else $error("bank 1 pad output wrong");

    AST_OUT_B2: assert property (
        (wr && bankSel == 2'h2 && regSel == GPX_REG_OUT)
        |=> mainPadOut[66:49] == $past(wdata[17:0]))
        else $error("bank 2 pad output wrong");

    AST_OUT_AON: assert property (
        (wr && bankSel == 2'h3 && regSel == GPX_REG_OUT)
        |=> aonPadOut == $past(wdata[19:0]))
        else $error("always-on pad output wrong");

    AST_DIR_B0: assert property (
        (wr && bankSel == 2'h0 && regSel == GPX_REG_DIR)
        |=> mainPadOe[21:0] == $past(wdata[21:0]))
        else $error("bank 0 pad enable wrong");

    AST_DIR_B1: assert property (
        (wr && bankSel == 2'h1 && regSel == GPX_REG_DIR)
        |=> mainPadOe[48:22] == $past(wdata[26:0]))
        else $error("bank 1 pad enable wrong");

    AST_DIR_B2: assert property (
        (wr && bankSel == 2'h2 && regSel == GPX_REG_DIR)
        |=> mainPadOe[66:49] == $past(wdata[17:0]))
        else $error("bank 2 pad enable wrong");

    // Without a write nothing on the pads moves
    AST_OUT_HOLD: assert property (
        !(wr && regSel == GPX_REG_OUT)
        |=> $stable(mainPadOut) && $stable(aonPadOut))
        else $error("pad output moved without a write");

    AST_DIR_HOLD: assert property (
        !(wr && regSel == GPX_REG_DIR)
        |=> $stable(mainPadOe) && $stable(aonPadOe))
        else $error("pad enable moved without a write");

    // Pad level and status reads of the remaining banks
    AST_PADIN_B0: assert property (
        (rd && bankSel == 2'h0 && regSel == GPX_REG_PADIN)
        |=> rdata == {10'h000, $past(mainPadIn[21:0])})
        else $error("bank 0 pad input read wrong");

    AST_PADIN_B2: assert property (
        (rd && bankSel == 2'h2 && regSel == GPX_REG_PADIN)
        |=> rdata == {14'h0000, $past(mainPadIn[66:49])})
        else $error("bank 2 pad input read wrong");

    AST_PADIN_AON: assert property (
        (rd && bankSel == 2'h3 && regSel == GPX_REG_PADIN)
        |=> rdata == {12'h000, $past(aonPadIn)})
        else $error("always-on pad input read wrong");

    AST_RAW_READ: assert property (
        (rd && bankSel == 2'h0 && regSel == GPX_REG_RAW)
        |=> rdata == $past(rawStat[0]))
        else $error("raw status read wrong");

    // Combined request has no mask of its own
    AST_IRQ_ALLMASK: assert property (
        ((&s_r.intMask[0][21:0]) && (&s_r.intMask[1][26:0])
         && (&s_r.intMask[2][17:0]) && (&s_r.intMask[3][19:0]))
        |-> !irq)
        else $error("request with every pin masked");

    AST_IRQ_RAISE: assert property (
        (rawStat[0][1] && !s_r.intMask[0][1])
        |-> irq)
        else $error("unmasked status did not raise request");

    // Pending edges stay until cleared, even on output pins
    AST_PEND_KEEP: assert property (
        (s_r.edgeRaw[0][0] && !(wr && bankSel == 2'h0 && regSel == GPX_REG_EOI))
        |=> s_r.edgeRaw[0][0])
        else $error("pending edge lost without a clear");

    AST_OUT_NO_LEVEL: assert property (
        (!s_r.trigEdge[0][2] && s_r.dir[0][2] && !s_r.edgeRaw[0][2])
        |-> !rawStat[0][2])
        else $error("level status on an output pin");

    // Clearing edge status, several bits at once
    AST_EOI_MULTI: assert property (
        (wr && bankSel == 2'h0 && regSel == GPX_REG_EOI && (&wdata[1:0])
         && (&s_r.trigEdge[0][1:0]) && !(|edgeSet[0][1:0]))
        |=> !(|s_r.edgeRaw[0][1:0]))
        else $error("multi-bit edge clear incomplete");

    AST_EOI_STAT: assert property (
        (wr && bankSel == 2'h0 && regSel == GPX_REG_EOI && wdata[0]
         && s_r.trigEdge[0][0] && !edgeSet[0][0])
        |=> !maskStat[0][0])
        else $error("edge clear left masked status");

    AST_SET_WINS: assert property (
        edgeSet[0][0]
        |=> s_r.edgeRaw[0][0])
        else $error("new edge lost to a clear");

    // Level status follows its source, direct or synchronised
    AST_LEVEL_FOLLOW: assert property (
        (!s_r.trigEdge[0][2] && !s_r.lvlSync[0][2] && !s_r.edgeRaw[0][2]
         && (mainPadIn[2] != s_r.polHigh[0][2]))
        |-> !rawStat[0][2])
        else $error("level status outlived its source");

    AST_SYNC_LEVEL: assert property (
        (!s_r.trigEdge[0][2] && s_r.lvlSync[0][2] && s_r.intEn[0][2]
         && !s_r.dir[0][2] && !s_r.edgeRaw[0][2])
        |-> rawStat[0][2] == ($past(mainPadIn[2], 2) == s_r.polHigh[0][2]))
        else $error("synchronised level status wrong");

    // Synchroniser timing and polarity on the other comparators
    AST_FALL_SYNC: assert property (
        fallBank[0][0]
        |-> (!$past(mainPadIn[0], 2) && $past(mainPadIn[0], 3)))
        else $error("falling edge not seen through synchroniser");

    AST_AON_RISE: assert property (
        riseBank[3][0]
        |-> ($past(aonPadIn[0], 2) && !$past(aonPadIn[0], 3)))
        else $error("always-on edge not seen through synchroniser");

    AST_POL_GATE: assert property (
        (s_r.trigEdge[0][0] && !s_r.polHigh[0][0] && !s_r.edgeRaw[0][0] && !fallBank[0][0])
        |=> !s_r.edgeRaw[0][0])
        else $error("edge of the wrong polarity latched");
endmodule // gpx_port
`default_nettype wire

/* dv/gpx_pad_model.sv */
// Board-side pad model: level seen on each pad of one domain
`timescale 1ns/1ps
`default_nettype none
module gpx_pad_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] padOut,
    input  wire logic [W-1:0] padOe,
    input  wire logic [W-1:0] extLvl,
    output logic      [W-1:0] padIn
);
    // Driven pads show their own output, released pads the board level
    assign padIn = (padOe & padOut) | (~padOe & extLvl);
endmodule // gpx_pad_model
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the pin port: registers, pads and interrupts
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import gpx_pkg::*;
;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic [GPX_ADDR_W-1:0]    addr = '0;
    logic [31:0]              wdata = '0;
    logic                     wr = 1'b0;
    logic                     rd = 1'b0;
    logic [31:0]              rdata, rv, d, m;
    logic                     irq;
    logic [GPX_MAIN_PINS-1:0] mainPadIn, mainPadOut, mainPadOe;
    logic [GPX_MAIN_PINS-1:0] mainExt = '0;
    logic [GPX_AON_PINS-1:0]  aonPadIn, aonPadOut, aonPadOe;
    logic [GPX_AON_PINS-1:0]  aonExt = '0;
    int                       errorCnt = 0;
    int                       cmpCount = 0;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    gpx_port u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .mainPadIn(mainPadIn), .mainPadOut(mainPadOut), .mainPadOe(mainPadOe),
        .aonPadIn(aonPadIn), .aonPadOut(aonPadOut), .aonPadOe(aonPadOe), .irq(irq));
    gpx_pad_model #(.W(GPX_MAIN_PINS)) u_main (.padOut(mainPadOut), .padOe(mainPadOe),
        .extLvl(mainExt), .padIn(mainPadIn));
    gpx_pad_model #(.W(GPX_AON_PINS)) u_aon (.padOut(aonPadOut), .padOe(aonPadOe),
        .extLvl(aonExt), .padIn(aonPadIn));

    // Valid bits of one bank word
    function automatic logic [31:0] bmask(input int b);
        return 32'((64'h1 << GPX_BANK_W[b]) - 64'h1);
    endfunction

    // Bank slice of a main/always-on pin vector
    function automatic logic [31:0] bsel(input int b, input logic [66:0] mv,
                                         input logic [19:0] av);
        return (b == 3 ? {12'h000, av} : 32'(mv >> GPX_BANK_LSB[b])) & bmask(b);
    endfunction

    // One-cycle write strobe; settles past the taking edge before returning
    task automatic wreg(input int b, input logic [5:0] o, input logic [31:0] v);
        @(posedge clk);
        addr  <= {b[1:0], o};
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rreg(input int b, input logic [5:0] o, output logic [31:0] v);
        @(posedge clk);
        addr <= {b[1:0], o};
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmpCount++;
        if (g !== e) begin
            errorCnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic testDone;
        $display("checks=%0d mismatches=%0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Random values per bank; bits above the bank width must read zero
    task automatic t_regs;
        mainExt <= 67'({$urandom, $urandom, $urandom});
        aonExt  <= 20'($urandom);
        for (int b = 0; b < GPX_NUM_BANKS; b++) begin
            chk(bsel(b, mainPadOe, aonPadOe), 32'h0000_0000);
            rreg(b, GPX_REG_OUT, rv);
            chk(rv, GPX_RST_VALUE);
            d = $urandom;
            m = (b == 0) ? 32'hFFFF_FFFF : $urandom;
            wreg(b, GPX_REG_OUT, d);
            wreg(b, GPX_REG_DIR, m);
            chk(bsel(b, mainPadOut, aonPadOut), d & bmask(b));
            chk(bsel(b, mainPadOe, aonPadOe), m & bmask(b));
            rreg(b, GPX_REG_DIR, rv);
            chk(rv, m & bmask(b));
            rreg(b, GPX_REG_PADIN, rv);
            chk(rv, ((d & m) | (~m & bsel(b, mainExt, aonExt))) & bmask(b));
            rreg(b, 6'h2C, rv);
            chk(rv, 32'h0000_0000);
            wreg(b, GPX_REG_DIR, 32'h0000_0000);
        end
        mainExt[2:0] <= 3'b100;
        $display("test regs done");
    endtask

    // Rising then falling edges on pins 0 and 1 of bank 0
    task automatic t_edge;
        for (int p = 1; p >= 0; p--) begin
            wreg(0, GPX_REG_TRIG, 32'h0000_0003);
            wreg(0, GPX_REG_POL, p ? 32'h0000_0003 : 32'h0000_0000);
            wreg(0, GPX_REG_INTEN, 32'h0000_0003);
            wreg(0, GPX_REG_EOI, 32'h0000_0003);
            @(posedge clk);
            mainExt[1:0] <= p ? 2'b11 : 2'b00;
            cyc(2);
            chk({31'h0, irq}, 32'h0);
            cyc(1);
            chk({31'h0, irq}, 32'h1);
            wreg(0, GPX_REG_MASK, 32'h0000_0001);
            rreg(0, GPX_REG_STAT, rv);
            chk(rv, 32'h0000_0002);
            chk({31'h0, irq}, 32'h1);
            wreg(0, GPX_REG_MASK, 32'h0000_0003);
            chk({31'h0, irq}, 32'h0);
            rreg(0, GPX_REG_RAW, rv);
            chk(rv, 32'h0000_0003);
            wreg(0, GPX_REG_MASK, 32'h0000_0000);
            wreg(0, GPX_REG_EOI, 32'h0000_0003);
            rreg(0, GPX_REG_RAW, rv);
            chk(rv, 32'h0000_0000);
            // Pending edge survives a switch to output; driven toggles raise nothing
            @(posedge clk);
            mainExt[0] <= ~p[0];
            cyc(4);
            wreg(0, GPX_REG_EOI, 32'h0000_0003);
            @(posedge clk);
            mainExt[0] <= p[0];
            cyc(4);
            wreg(0, GPX_REG_OUT, 32'(p));
            wreg(0, GPX_REG_DIR, 32'h0000_0001);
            rreg(0, GPX_REG_RAW, rv);
            chk(rv, 32'h0000_0001);
            wreg(0, GPX_REG_EOI, 32'h0000_0001);
            wreg(0, GPX_REG_OUT, 32'(1 - p));
            cyc(4);
            wreg(0, GPX_REG_OUT, 32'(p));
            cyc(4);
            rreg(0, GPX_REG_RAW, rv);
            chk(rv, 32'h0000_0000);
            wreg(0, GPX_REG_DIR, 32'h0000_0000);
        end
        $display("test edge done");
    endtask

    // Pin 2: direct active-low level, then synchronised active-high level
    task automatic t_level;
        wreg(0, GPX_REG_INTEN, 32'h0000_0000);
        wreg(0, GPX_REG_EOI, 32'h0000_0003);
        wreg(0, GPX_REG_TRIG, 32'h0000_0000);
        wreg(0, GPX_REG_POL, 32'h0000_0000);
        wreg(0, GPX_REG_LSYNC, 32'h0000_0000);
        wreg(0, GPX_REG_INTEN, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        mainExt[2] <= 1'b0;
        #1;
        chk({31'h0, irq}, 32'h1);
        wreg(0, GPX_REG_EOI, 32'h0000_0004);
        rreg(0, GPX_REG_RAW, rv);
        chk(rv, 32'h0000_0004);
        wreg(0, GPX_REG_MASK, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0);
        wreg(0, GPX_REG_MASK, 32'h0000_0000);
        chk({31'h0, irq}, 32'h1);
        wreg(0, GPX_REG_POL, 32'h0000_0004);
        wreg(0, GPX_REG_LSYNC, 32'h0000_0004);
        @(posedge clk);
        mainExt[2] <= 1'b1;
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        cyc(1);
        chk({31'h0, irq}, 32'h1);
        wreg(0, GPX_REG_INTEN, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0);
        $display("test level done");
    endtask

    // Main sequence: seed once, two reset cycles, then the tests
    initial begin
        rv = $urandom(71406);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_edge();
        t_level();
        testDone();
    end

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        errorCnt++;
        testDone();
    end
endmodule // tb_top
`default_nettype wire
